// File: design/icl_pkg.sv
// What this block does
// - barrier completion waits until every pending store has reached memory
// - with bus broadcast on, barrier completes only after a good broadcast
// - tlb sync goes to completion buffer only, finished on dispatch
// - tlb sync retirement waits for the external sync input
// - primary 19 condition-bit logicals: system unit, 1 cycle, serialized
// - decode cr and/andc/eqv/nand/nor/or/orc/xor and field move codes
// - primary 31 cr moves 512/19/144: system unit, 1 cycle, serialized
// - full unit runs all integer ops; reduced unit excludes multiply/divide
// - simple integer ops go to either unit, 1 cycle, not serialized
// - word divide 491/459 runs only in full unit, 19 cycles
// - carry-consuming extended add/subtract: 1 cycle, execution-serialized
// - word trap 31/4 and trap immediate 3 take 2 cycles either unit
// - decode immediate arithmetic and logic forms by primary opcode
// - decode primary 31 add, subtract, logic and compare codes
// - decode clz, sign-extend, shifts and rotate primaries 20/21/23
// - barrier 31/598 runs in system unit, 3 cycles with no stores and bus broadcast off
package icl_pkg;
   localparam int LAT_W = 5;
   typedef logic [LAT_W-1:0] icl_lat_t;
   // primary opcodes
   localparam logic [5:0] P_TWI = 6'h03;
   localparam logic [5:0] P_MULLI = 6'h07;
   localparam logic [5:0] P_SUBFIC = 6'h08;
   localparam logic [5:0] P_CMPLI = 6'h0a;
   localparam logic [5:0] P_CMPI = 6'h0b;
   localparam logic [5:0] P_ADDIC = 6'h0c;
   localparam logic [5:0] P_ADDIC_REC = 6'h0d;
   localparam logic [5:0] P_ADDI = 6'h0e;
   localparam logic [5:0] P_ADDIS = 6'h0f;
   localparam logic [5:0] P_CRLOG = 6'h13;
   localparam logic [5:0] P_ROT_INS = 6'h14;
   localparam logic [5:0] P_ROT_MASK = 6'h15;
   localparam logic [5:0] P_ROT_REG = 6'h17;
   localparam logic [5:0] P_ORI = 6'h18;
   localparam logic [5:0] P_ORIS = 6'h19;
   localparam logic [5:0] P_XORI = 6'h1a;
   localparam logic [5:0] P_XORIS = 6'h1b;
   localparam logic [5:0] P_ANDI = 6'h1c;
   localparam logic [5:0] P_ANDIS = 6'h1d;
   localparam logic [5:0] P_EXT = 6'h1f;
   // primary 19 extended codes
   localparam logic [9:0] X_CRAND = 10'h101;
   localparam logic [9:0] X_CRANDC = 10'h081;
   localparam logic [9:0] X_CREQV = 10'h121;
   localparam logic [9:0] X_CRNAND = 10'h0e1;
   localparam logic [9:0] X_CRNOR = 10'h021;
   localparam logic [9:0] X_CROR = 10'h1c1;
   localparam logic [9:0] X_CRORC = 10'h1a1;
   localparam logic [9:0] X_CRXOR = 10'h0c1;
   localparam logic [9:0] X_CRFMOVE = 10'h000;
   // primary 31 ten-bit extended codes
   localparam logic [9:0] X_XER_TO_CR = 10'h200;
   localparam logic [9:0] X_CR_READ = 10'h013;
   localparam logic [9:0] X_CR_WRITE = 10'h090;
   localparam logic [9:0] X_BARRIER = 10'h256;
   localparam logic [9:0] X_TLBSYNC = 10'h236;
   localparam logic [9:0] X_WORD_TRAP = 10'h004;
   localparam logic [9:0] X_AND = 10'h01c;
   localparam logic [9:0] X_ANDC = 10'h03c;
   localparam logic [9:0] X_OR = 10'h1bc;
   localparam logic [9:0] X_ORC = 10'h19c;
   localparam logic [9:0] X_XOR = 10'h13c;
   localparam logic [9:0] X_NAND = 10'h1dc;
   localparam logic [9:0] X_NOR = 10'h07c;
   localparam logic [9:0] X_EQV = 10'h11c;
   localparam logic [9:0] X_CMP = 10'h000;
   localparam logic [9:0] X_CMPL = 10'h020;
   localparam logic [9:0] X_CLZ = 10'h01a;
   localparam logic [9:0] X_EXT_BYTE = 10'h3ba;
   localparam logic [9:0] X_EXT_HALF = 10'h39a;
   localparam logic [9:0] X_SHL = 10'h018;
   localparam logic [9:0] X_SHR = 10'h218;
   localparam logic [9:0] X_SHRA = 10'h318;
   localparam logic [9:0] X_SHRA_IMM = 10'h338;
   localparam logic [9:0] X_MUL_HI_U = 10'h00b;
   localparam logic [9:0] X_MUL_HI = 10'h04b;
   // primary 31 nine-bit codes, overflow-enable bit excluded
   localparam logic [8:0] X_ADD = 9'h10a;
   localparam logic [8:0] X_ADDC = 9'h00a;
   localparam logic [8:0] X_SUBF = 9'h028;
   localparam logic [8:0] X_SUBFC = 9'h008;
   localparam logic [8:0] X_NEG = 9'h068;
   localparam logic [8:0] X_ADDE = 9'h08a;
   localparam logic [8:0] X_ADDME = 9'h0ea;
   localparam logic [8:0] X_ADDZE = 9'h0ca;
   localparam logic [8:0] X_SUBFE = 9'h088;
   localparam logic [8:0] X_SUBFME = 9'h0e8;
   localparam logic [8:0] X_SUBFZE = 9'h0c8;
   localparam logic [8:0] X_MUL_LO = 9'h0eb;
   localparam logic [8:0] X_DIV = 9'h1eb;
   localparam logic [8:0] X_DIV_U = 9'h1cb;
   // latencies in cycles
   localparam icl_lat_t LAT_SIMPLE = 5'd1;
   localparam icl_lat_t LAT_TRAP = 5'd2;
   localparam icl_lat_t LAT_BARRIER = 5'd3;
   localparam icl_lat_t LAT_DIV = 5'd19;
   localparam icl_lat_t LAT_MUL_MIN = 5'd2;
   localparam icl_lat_t LAT_MULLI_MAX = 5'd3;
   localparam icl_lat_t LAT_MUL_MAX = 5'd5;
   localparam icl_lat_t LAT_MULHU_MAX = 5'd6;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_EXEC = 4'b0010,
      ST_DRAIN = 4'b0100,
      ST_BCAST = 4'b1000
   } icl_state_e;
endpackage : icl_pkg

// File: design/icl_seq_if.sv
`timescale 1ns/100ps
interface icl_seq_if;
   logic barrier_start;
   logic tlbsync_retire;
   logic barrier_done;
   logic barrier_busy;
   logic bcast_req;
   logic tlbsync_done;
   modport decode (output barrier_start, output tlbsync_retire,
      input barrier_done, input barrier_busy, input bcast_req,
      input tlbsync_done);
   modport seq (input barrier_start, input tlbsync_retire,
      output barrier_done, output barrier_busy, output bcast_req,
      output tlbsync_done);
endinterface : icl_seq_if

// File: design/icl_barrier_seq.sv
`timescale 1ns/100ps
module icl_barrier_seq
   import icl_pkg::*;
(
   input logic clk_sys,
   input logic reset,
   icl_seq_if.seq sq,
   input logic store_queue_empty,
   input logic bus_broadcast_enable,
   input logic bus_broadcast_ok,
   input logic tlb_invalidate_sync_in
);
   icl_state_e state_q;
   icl_lat_t cnt_q;
   logic sync_meta_q;
   logic sync_s_q;
   logic done_q;
   logic tlb_done_q;
   // busy and request kept as flops so the ports come straight from them
   logic busy_q;
   logic bcast_q;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         done_q <= 1'b0;
         busy_q <= 1'b0;
         bcast_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (sq.barrier_start) begin
                  state_q <= ST_EXEC;
                  busy_q <= 1'b1;
                  cnt_q <= LAT_BARRIER - 5'd1;
               end
            end
            ST_EXEC: begin
               if (cnt_q != '0) begin
                  cnt_q <= cnt_q - 5'd1;
               end else if (!store_queue_empty) begin
                  state_q <= ST_DRAIN;
               end else if (bus_broadcast_enable) begin
                  state_q <= ST_BCAST;
                  bcast_q <= 1'b1;
               end else begin
                  state_q <= ST_IDLE;
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
               end
            end
            ST_DRAIN: begin
               // stores keep draining; broadcast only after memory is clean
               if (store_queue_empty && bus_broadcast_enable) begin
                  state_q <= ST_BCAST;
                  bcast_q <= 1'b1;
               end else if (store_queue_empty) begin
                  state_q <= ST_IDLE;
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
               end
            end
            ST_BCAST: begin
               if (bus_broadcast_ok) begin
                  state_q <= ST_IDLE;
                  busy_q <= 1'b0;
                  bcast_q <= 1'b0;
                  done_q <= 1'b1;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               busy_q <= 1'b0;
               bcast_q <= 1'b0;
            end
         endcase
      end
   end

   // the sync pin comes from system logic on another timing domain
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sync_meta_q <= 1'b0;
         sync_s_q <= 1'b0;
      end else begin
         sync_meta_q <= tlb_invalidate_sync_in;
         sync_s_q <= sync_meta_q;
      end
   end

   // one pulse per retirement; partner drops its request after the pulse
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         tlb_done_q <= 1'b0;
      end else begin
         tlb_done_q <= sq.tlbsync_retire && sync_s_q && !tlb_done_q;
      end
   end

   assign sq.barrier_done = done_q;
   assign sq.barrier_busy = busy_q;
   assign sq.bcast_req = bcast_q;
   assign sq.tlbsync_done = tlb_done_q;
endmodule : icl_barrier_seq

// File: design/icl_op_decoder.sv
`timescale 1ns/100ps
module icl_op_decoder
   import icl_pkg::*;
(
   input logic clk_sys,
   input logic reset,
   input logic [31:0] instr_word,
   input logic dispatch_valid,
   input logic store_queue_empty,
   input logic bus_broadcast_enable,
   input logic bus_broadcast_ok,
   input logic tlbsync_retire,
   input logic tlb_invalidate_sync_in,
   output logic handled,
   output logic integer_unit_full,
   output logic integer_unit_reduced,
   output logic system_register_unit,
   output logic completion_only,
   output logic finished_at_dispatch,
   output logic exec_serialized,
   output icl_lat_t latency_min,
   output icl_lat_t latency_max,
   output logic barrier_busy,
   output logic barrier_complete,
   output logic bus_broadcast_req,
   output logic tlbsync_retire_done
);
   // decode outputs are combinational so dispatch sees them with the opcode;
   // only the sequencing outputs are registered
   logic [5:0] prim;
   logic [9:0] ext10;
   logic [8:0] ext9;
   logic is_barrier;
   icl_seq_if sq ();

   assign prim = instr_word[31:26];
   assign ext10 = instr_word[10:1];
   assign ext9 = instr_word[9:1];

   always_comb begin
      handled = 1'b0;
      integer_unit_full = 1'b0;
      integer_unit_reduced = 1'b0;
      system_register_unit = 1'b0;
      completion_only = 1'b0;
      finished_at_dispatch = 1'b0;
      exec_serialized = 1'b0;
      latency_min = '0;
      latency_max = '0;
      is_barrier = 1'b0;
      case (prim)
         P_CRLOG: begin
            if (ext10 inside {X_CRAND, X_CRANDC, X_CREQV, X_CRNAND, X_CRNOR,
                  X_CROR, X_CRORC, X_CRXOR, X_CRFMOVE}) begin
               handled = 1'b1;
               system_register_unit = 1'b1;
               exec_serialized = 1'b1;
               latency_min = LAT_SIMPLE;
               latency_max = LAT_SIMPLE;
            end
         end
         P_EXT: begin
            // ten-bit codes first: cr moves overlap nine-bit zero patterns
            if (ext10 inside {X_XER_TO_CR, X_CR_READ, X_CR_WRITE}) begin
               handled = 1'b1;
               system_register_unit = 1'b1;
               exec_serialized = 1'b1;
               latency_min = LAT_SIMPLE;
               latency_max = LAT_SIMPLE;
            end else if (ext10 == X_BARRIER) begin
               handled = 1'b1;
               system_register_unit = 1'b1;
               is_barrier = 1'b1;
               latency_min = LAT_BARRIER;
               latency_max = LAT_BARRIER;
            end else if (ext10 == X_TLBSYNC) begin
               handled = 1'b1;
               completion_only = 1'b1;
               finished_at_dispatch = dispatch_valid;
            end else if (ext10 == X_WORD_TRAP) begin
               handled = 1'b1;
               integer_unit_full = 1'b1;
               integer_unit_reduced = 1'b1;
               latency_min = LAT_TRAP;
               latency_max = LAT_TRAP;
            end else if (ext10 inside {X_AND, X_ANDC, X_OR, X_ORC, X_XOR,
                  X_NAND, X_NOR, X_EQV, X_CMP, X_CMPL}
                  || ext10 inside {X_CLZ, X_EXT_BYTE, X_EXT_HALF, X_SHL,
                  X_SHR, X_SHRA, X_SHRA_IMM}
                  || ext9 inside {X_ADD, X_ADDC, X_SUBF, X_SUBFC,
                  X_NEG}) begin
               handled = 1'b1;
               integer_unit_full = 1'b1;
               integer_unit_reduced = 1'b1;
               latency_min = LAT_SIMPLE;
               latency_max = LAT_SIMPLE;
            end else if (ext9 inside {X_ADDE, X_ADDME, X_ADDZE, X_SUBFE,
                  X_SUBFME, X_SUBFZE}) begin
               handled = 1'b1;
               integer_unit_full = 1'b1;
               integer_unit_reduced = 1'b1;
               exec_serialized = 1'b1;
               latency_min = LAT_SIMPLE;
               latency_max = LAT_SIMPLE;
            end else if (ext10 == X_MUL_HI_U) begin
               handled = 1'b1;
               integer_unit_full = 1'b1;
               latency_min = LAT_MUL_MIN;
               latency_max = LAT_MULHU_MAX;
            end else if (ext10 == X_MUL_HI || ext9 == X_MUL_LO) begin
               handled = 1'b1;
               integer_unit_full = 1'b1;
               latency_min = LAT_MUL_MIN;
               latency_max = LAT_MUL_MAX;
            end else if (ext9 inside {X_DIV, X_DIV_U}) begin
               handled = 1'b1;
               integer_unit_full = 1'b1;
               latency_min = LAT_DIV;
               latency_max = LAT_DIV;
            end
         end
         P_SUBFIC, P_CMPLI, P_CMPI, P_ADDIC, P_ADDIC_REC, P_ADDI, P_ADDIS,
         P_ORI, P_ORIS, P_XORI, P_XORIS, P_ANDI, P_ANDIS,
         P_ROT_INS, P_ROT_MASK, P_ROT_REG: begin
            handled = 1'b1;
            integer_unit_full = 1'b1;
            integer_unit_reduced = 1'b1;
            latency_min = LAT_SIMPLE;
            latency_max = LAT_SIMPLE;
         end
         P_TWI: begin
            handled = 1'b1;
            integer_unit_full = 1'b1;
            integer_unit_reduced = 1'b1;
            latency_min = LAT_TRAP;
            latency_max = LAT_TRAP;
         end
         P_MULLI: begin
            handled = 1'b1;
            integer_unit_full = 1'b1;
            latency_min = LAT_MUL_MIN;
            latency_max = LAT_MULLI_MAX;
         end
         default: begin
            handled = 1'b0;
         end
      endcase
   end

   // a barrier dispatched while one is in flight is not accepted
   assign sq.barrier_start = dispatch_valid && is_barrier && !sq.barrier_busy;
   assign sq.tlbsync_retire = tlbsync_retire;
   assign barrier_busy = sq.barrier_busy;
   assign barrier_complete = sq.barrier_done;
   assign bus_broadcast_req = sq.bcast_req;
   assign tlbsync_retire_done = sq.tlbsync_done;

   icl_barrier_seq u_seq (
      .clk_sys(clk_sys),
      .reset(reset),
      .sq(sq),
      .store_queue_empty(store_queue_empty),
      .bus_broadcast_enable(bus_broadcast_enable),
      .bus_broadcast_ok(bus_broadcast_ok),
      .tlb_invalidate_sync_in(tlb_invalidate_sync_in)
   );
endmodule : icl_op_decoder

// File: dv/icl_op_decoder_monitor.sv
`timescale 1ns/100ps
module icl_op_decoder_monitor
   import icl_pkg::*;
(
   input logic clk_sys,
   input logic reset,
   input logic [31:0] instr_word,
   input logic dispatch_valid,
   input logic store_queue_empty,
   input logic bus_broadcast_enable,
   input logic bus_broadcast_ok,
   input logic tlbsync_retire,
   input logic tlb_invalidate_sync_in,
   input logic handled,
   input logic integer_unit_full,
   input logic integer_unit_reduced,
   input logic system_register_unit,
   input logic completion_only,
   input logic finished_at_dispatch,
   input logic exec_serialized,
   input icl_lat_t latency_min,
   input icl_lat_t latency_max,
   input logic barrier_busy,
   input logic barrier_complete,
   input logic bus_broadcast_req,
   input logic tlbsync_retire_done
);
   logic p31;
   logic any_unit;
   assign p31 = (instr_word[31:26] == 6'h1f);
   assign any_unit = integer_unit_full | integer_unit_reduced |
      system_register_unit;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   property p_tlb_unit;
      completion_only |-> !any_unit && latency_max == 5'h00;
   endproperty
   a_tlb_unit: assert property (p_tlb_unit)
      else $error("tlb sync given an execution unit");
   property p_tlb_fin;
      dispatch_valid && p31 && instr_word[10:1] == 10'h236
         |-> finished_at_dispatch && completion_only;
   endproperty
   a_tlb_fin: assert property (p_tlb_fin)
      else $error("tlb sync not finished at dispatch");
   property p_cr_unit;
      handled && instr_word[31:26] == 6'h13 |-> system_register_unit &&
         exec_serialized && !integer_unit_full && latency_min == 5'h01;
   endproperty
   a_cr_unit: assert property (p_cr_unit)
      else $error("condition op misrouted");
   property p_div;
      p31 && instr_word[9:1] inside {9'h1eb, 9'h1cb} |-> integer_unit_full
         && !integer_unit_reduced && latency_min == 5'h13;
   endproperty
   a_div: assert property (p_div)
      else $error("divide routing or latency wrong");
   property p_mulhu;
      p31 && instr_word[10:1] == 10'h00b
         |-> latency_min == 5'h02 && latency_max == 5'h06;
   endproperty
   a_mulhu: assert property (p_mulhu)
      else $error("unsigned high multiply range wrong");
   property p_unknown;
      !handled |-> !any_unit && !exec_serialized && !completion_only;
   endproperty
   a_unknown: assert property (p_unknown)
      else $error("unhandled opcode drives outputs");
   property p_bar_store;
      barrier_complete && !bus_broadcast_enable |-> $past(store_queue_empty);
   endproperty
   a_bar_store: assert property (p_bar_store)
      else $error("barrier completed with stores pending");
   property p_bar_bcast;
      barrier_complete && bus_broadcast_enable
         |-> $past(bus_broadcast_req) && $past(bus_broadcast_ok);
   endproperty
   a_bar_bcast: assert property (p_bar_bcast)
      else $error("barrier completed without good broadcast");
   property p_bar_lat;
      $rose(barrier_busy) && !bus_broadcast_enable ##2 store_queue_empty
         |-> ##1 barrier_complete && !barrier_busy;
   endproperty
   a_bar_lat: assert property (p_bar_lat)
      else $error("barrier latency not three cycles");
   property p_tlb_pin;
      !tlb_invalidate_sync_in [*4] |-> !tlbsync_retire_done;
   endproperty
   a_tlb_pin: assert property (p_tlb_pin)
      else $error("tlb sync retired with sync input low");
endmodule : icl_op_decoder_monitor

// File: dv/icl_core_partner.sv
`timescale 1ns/100ps
module icl_core_partner (
   input logic clk_sys,
   input logic reset,
   input logic store_load,
   input logic [7:0] store_count,
   input logic [7:0] ok_delay,
   input logic bus_broadcast_req,
   output logic store_queue_empty,
   output logic bus_broadcast_ok
);
   logic [7:0] pend_q;
   logic [7:0] wait_q;
   // one store drains per cycle, a crude stand-in for the memory path
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pend_q <= 8'h00;
      end else if (store_load) begin
         pend_q <= store_count;
      end else if (pend_q != 8'h00) begin
         pend_q <= pend_q - 8'h01;
      end
   end
   assign store_queue_empty = (pend_q == 8'h00);
   // success pulse comes ok_delay + 1 cycles into a request, once
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wait_q <= 8'h00;
         bus_broadcast_ok <= 1'b0;
      end else begin
         bus_broadcast_ok <= 1'b0;
         if (!bus_broadcast_req || bus_broadcast_ok) begin
            wait_q <= 8'h00;
         end else if (wait_q == ok_delay) begin
            bus_broadcast_ok <= 1'b1;
         end else begin
            wait_q <= wait_q + 8'h01;
         end
      end
   end
endmodule : icl_core_partner

// File: dv/int_cr_op_unit_latency_decoder_test.sv
`timescale 1ns/100ps
bind icl_op_decoder icl_op_decoder_monitor i_icl_op_decoder_monitor (
   .clk_sys, .reset, .instr_word, .dispatch_valid, .store_queue_empty,
   .bus_broadcast_enable, .bus_broadcast_ok, .tlbsync_retire,
   .tlb_invalidate_sync_in, .handled, .integer_unit_full,
   .integer_unit_reduced, .system_register_unit, .completion_only,
   .finished_at_dispatch, .exec_serialized, .latency_min, .latency_max,
   .barrier_busy, .barrier_complete, .bus_broadcast_req,
   .tlbsync_retire_done);
module int_cr_op_unit_latency_decoder_test
   import icl_pkg::*;
;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [31:0] instr_word = 32'h0;
   logic dispatch_valid = 1'b0;
   logic bus_broadcast_enable = 1'b0;
   logic tlbsync_retire = 1'b0;
   logic tlb_invalidate_sync_in = 1'b0;
   logic store_load = 1'b0;
   logic [7:0] store_count = 8'h00;
   logic [7:0] ok_delay = 8'h00;
   logic store_queue_empty, bus_broadcast_ok, handled, integer_unit_full;
   logic integer_unit_reduced, system_register_unit, completion_only;
   logic finished_at_dispatch, exec_serialized, barrier_busy;
   logic barrier_complete, bus_broadcast_req, tlbsync_retire_done;
   icl_lat_t latency_min, latency_max;
   logic [31:0] w;
   int seed = 52;
   int bad_count = 0;
   int checks = 0;
   int n;
   icl_op_decoder i_icl_op_decoder (
      .clk_sys, .reset, .instr_word, .dispatch_valid, .store_queue_empty,
      .bus_broadcast_enable, .bus_broadcast_ok, .tlbsync_retire,
      .tlb_invalidate_sync_in, .handled, .integer_unit_full,
      .integer_unit_reduced, .system_register_unit, .completion_only,
      .finished_at_dispatch, .exec_serialized, .latency_min, .latency_max,
      .barrier_busy, .barrier_complete, .bus_broadcast_req,
      .tlbsync_retire_done);
   icl_core_partner i_icl_core_partner (
      .clk_sys, .reset, .store_load, .store_count, .ok_delay,
      .bus_broadcast_req, .store_queue_empty, .bus_broadcast_ok);
   initial begin
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic conclude();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // flags: handled full reduced system completion serialized
   function automatic logic [16:0] exp_dec(input logic [31:0] v,
      input logic dv);
      logic [5:0] p;
      logic [9:0] e;
      logic [8:0] x;
      logic [15:0] r;
      p = v[31:26];
      e = v[10:1];
      x = v[9:1];
      r = 16'h0;
      if (p inside {6'h08, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h14,
         6'h15, 6'h17, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c, 6'h1d})
         r = {6'h38, 5'h01, 5'h01};
      else if (p == 6'h03) r = {6'h38, 5'h02, 5'h02};
      else if (p == 6'h07) r = {6'h30, 5'h02, 5'h03};
      else if (p == 6'h13 && e inside {10'h101, 10'h081, 10'h121, 10'h0e1,
         10'h021, 10'h1c1, 10'h1a1, 10'h0c1, 10'h000})
         r = {6'h25, 5'h01, 5'h01};
      else if (p == 6'h1f) begin
         if (e inside {10'h200, 10'h013, 10'h090}) r = {6'h25, 5'h01, 5'h01};
         else if (e == 10'h256) r = {6'h24, 5'h03, 5'h03};
         else if (e == 10'h236) r = {6'h22, 5'h00, 5'h00};
         else if (e == 10'h004) r = {6'h38, 5'h02, 5'h02};
         else if (e == 10'h00b) r = {6'h30, 5'h02, 5'h06};
         else if (e == 10'h04b) r = {6'h30, 5'h02, 5'h05};
         else if (e inside {10'h01c, 10'h03c, 10'h1bc, 10'h19c, 10'h13c,
            10'h1dc, 10'h07c, 10'h11c, 10'h000, 10'h020, 10'h01a, 10'h3ba,
            10'h39a, 10'h018, 10'h218, 10'h318, 10'h338})
            r = {6'h38, 5'h01, 5'h01};
         else if (x == 9'h0eb) r = {6'h30, 5'h02, 5'h05};
         else if (x inside {9'h1eb, 9'h1cb}) r = {6'h30, 5'h13, 5'h13};
         else if (x inside {9'h08a, 9'h0ea, 9'h0ca, 9'h088, 9'h0e8, 9'h0c8})
            r = {6'h39, 5'h01, 5'h01};
         else if (x inside {9'h10a, 9'h00a, 9'h028, 9'h008, 9'h068})
            r = {6'h38, 5'h01, 5'h01};
      end
      return {r, r[11] & dv};
   endfunction : exp_dec
   task automatic step(input logic [31:0] v, input logic dv);
      @(posedge clk_sys);
      instr_word <= v;
      dispatch_valid <= dv;
      @(negedge clk_sys);
      chk({handled, integer_unit_full, integer_unit_reduced,
         system_register_unit, completion_only, exec_serialized, latency_min,
         latency_max, finished_at_dispatch}, exp_dec(v, dv));
   endtask : step
   // edges from the taking edge to completion must land in lo..hi
   task automatic bar(input int pend, input logic bc, input int lo,
      input int hi);
      @(posedge clk_sys);
      instr_word <= {6'h1f, 15'h0, 10'h256, 1'b0};
      dispatch_valid <= 1'b1;
      bus_broadcast_enable <= bc;
      store_load <= 1'b1;
      store_count <= 8'(pend);
      ok_delay <= 8'($random(seed)) & 8'h07;
      @(posedge clk_sys);
      dispatch_valid <= 1'b0;
      store_load <= 1'b0;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
         #1;
      end while (barrier_complete !== 1'b1 && n < 300);
      chk(17'(n >= lo && n <= hi), 17'h1);
   endtask : bar
   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      conclude();
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      reset <= 1'b0;
      for (int k = 0; k < 2048; k++) begin
         w = {k[10] ? 6'h1f : 6'h13, 15'($random(seed)), k[9:0],
            1'($random(seed))};
         step(w, 1'($random(seed)));
      end
      for (int k = 0; k < 256; k++) begin
         w = $random(seed);
         w[31:26] = k[5:0];
         step(w, 1'($random(seed)));
      end
      repeat (8) step(32'h0, 1'b0);
      bar(0, 1'b0, 3, 3);
      bar(6, 1'b0, 7, 8);
      bar(0, 1'b1, 4, 20);
      bar(4, 1'b1, 6, 24);
      @(posedge clk_sys);
      bus_broadcast_enable <= 1'b0;
      tlbsync_retire <= 1'b1;
      // sync input low: retirement must stall however long
      repeat (8) begin
         @(negedge clk_sys);
         chk(17'(tlbsync_retire_done), 17'h0);
      end
      @(posedge clk_sys);
      tlb_invalidate_sync_in <= 1'b1;
      // two synchroniser edges, then the taking edge
      repeat (3) @(posedge clk_sys);
      tlbsync_retire <= 1'b0;
      @(negedge clk_sys);
      chk(17'(tlbsync_retire_done), 17'h1);
      repeat (4) @(posedge clk_sys);
      tlbsync_retire <= 1'b1;
      @(posedge clk_sys);
      tlbsync_retire <= 1'b0;
      @(negedge clk_sys);
      chk(17'(tlbsync_retire_done), 17'h1);
      @(negedge clk_sys);
      chk(17'(tlbsync_retire_done), 17'h0);
      conclude();
   end
endmodule : int_cr_op_unit_latency_decoder_test
